/* design/misc_cfg_consts.svh */
/*
 * Offsets, field positions, reset values and constants of the
 * miscellaneous configuration bank.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
`ifndef MISC_CFG_CONSTS_SVH
`define MISC_CFG_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CHIP_IDENTITY 12'h000
`define OFS_SERIAL_WIDTH 12'h188
`define OFS_AFR_ENABLE 12'h57C
`define OFS_UNDERRUN 12'h60C
`define OFS_LINE_MAX 12'h610
`define OFS_FRAC_PCLK 12'h614
`define OFS_DUAL_PIXEL 12'h618
`define OFS_IRQ_STATUS 12'h620
`define OFS_IRQ_MASK 12'h624

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SW_DUMMY_BIT 2
`define FPC_RANGE_LSB 10
`define CHIP_ID_VALUE 8'h5A // Arbitrary value, not any real part code
`define RST_SERIAL_WIDTH 3'h0
`define RST_AFR_ENABLE 1'h1
`define RST_LINE_MAX 12'h000
`define RST_FRAC_PCLK 12'h08A
`define RST_DUAL_PIXEL 1'h0
`define IRQ_BIT_UNDERRUN 0
`define IRQ_BIT_FPC_CMD 1
`define IRQ_WIDTH 2

`endif

/* design/misc_cfg_pkg.sv */
/*
 * Types shared by the configuration bank files.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none
package misc_cfg_pkg;
  // Host serial lane width codes
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL = 2'h1,
    LANE_QUAD = 2'h2,
    LANE_UNDEF = 2'h3
  } lane_width_t;

  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_DATA = 2'b10
  } bus_phase_t;
endpackage
`default_nettype wire

/* design/underrun_counter.sv */
/*
 * Saturation-free 32-bit counter of underrun lines.
 * Assumes the underrun strobe is a one-cycle pulse synchronous to MCLK.
 */
`default_nettype none
module underrun_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_underrun,
  output logic [31:0] count,
  output logic bumped
);
  typedef struct packed {
    logic [31:0] cnt;
    logic bump;
  } cnt_state_t;

  cnt_state_t st_reg;
  cnt_state_t st_next;

  // Wraps at 2^32; host compares samples, so wrap is harmless
  always_comb
  begin
    st_next = st_reg;
    st_next.bump = line_underrun;
    if (line_underrun)
    begin
      st_next.cnt = st_reg.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.cnt;
  assign bumped = st_reg.bump;

  AST_CNT_INC: assert property (@(posedge clk) disable iff (!rst_n)
    line_underrun |=> count == $past(count) + 32'h00000001)
    else $error("Underrun counter did not step by one");
  AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !line_underrun |=> $stable(count))
    else $error("Underrun counter moved without an underrun");
endmodule
`default_nettype wire

/* design/misc_cfg_regs.sv */
/*
 * Miscellaneous configuration and status register bank of a display
 * controller, reached over AHB-Lite, with a line underrun counter,
 * command-processor update path and a maskable interrupt.
 * Assumes a single AHB-Lite master, word transfers, MCLK 40 MHz.
 */
// What this block does
// - Offset zero reads a fixed read-only 8-bit identity code in low byte
// - Serial width bit 2 adds one dummy byte before serial read data
// - Two-bit lane field: 00 single, 01 dual, 10 quad, 11 undefined
// - Adaptive frame-rate bit 0 enables slowdown; resets enabled
// - 32-bit read-only underrun counter, reset zero, counts underrun lines
// - 12-bit maximum pixel clocks per line for adaptive horizontal sync
// - Zero in line maximum disables adaptive horizontal sync; resets zero
// - Fractional clock bits 11:10 select range; register resets to 0x8A
// - Fractional clock bits 9:0 set frequency, used in external sync
// - Pixel frequency command from command processor also updates register
// - Dual-pixel bit 0 chooses one or two pixels per pixel clock
`include "misc_cfg_consts.svh"
`default_nettype none
module misc_cfg_regs (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic LINE_UNDERRUN,
  input wire logic FPC_CMD_VALID,
  input wire logic [11:0] FPC_CMD_DATA,
  input wire logic EXT_SYNC_SEL,
  output logic [1:0] LANE_WIDTH,
  output logic READ_DUMMY_EN,
  output logic AFR_EN,
  output logic ADAPT_HSYNC_EN,
  output logic [11:0] LINE_MAX,
  output logic [1:0] FPC_RANGE,
  output logic [9:0] FPC_FREQ,
  output logic FPC_ACTIVE,
  output logic DUAL_PIXEL,
  output logic IRQ
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    misc_cfg_pkg::bus_phase_t phase;
    logic [11:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic [2:0] serial_width;
    logic afr_en;
    logic [11:0] line_max;
    logic [11:0] frac_pclk;
    logic dual_pixel;
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;
  } bank_state_t;

  bank_state_t st_reg;
  bank_state_t st_next;
  logic [31:0] underrun_count;
  logic underrun_bumped;
  logic addr_take;
  logic [31:0] read_word;
  logic [`IRQ_WIDTH-1:0] irq_events;
  logic [`IRQ_WIDTH-1:0] irq_read_clr;
  logic wr_now;

  // ****************************************************************
  // Underrun counter
  // ****************************************************************
  underrun_counter u_underrun (
    .clk(MCLK),
    .rst_n(RSTN),
    .line_underrun(LINE_UNDERRUN),
    .count(underrun_count),
    .bumped(underrun_bumped)
  );

  // Address phase accepted; slave never stalls so HREADY gates it
  assign addr_take = HSEL && HTRANS[1] && HREADY;
  assign wr_now = (st_reg.phase == misc_cfg_pkg::PH_DATA) && st_reg.wr;

  // Readback mux; reserved bits zero, unmapped reads zero
  always_comb
  begin
    read_word = 32'h00000000;
    unique case (HADDR)
      `OFS_CHIP_IDENTITY: read_word[7:0] = `CHIP_ID_VALUE;
      `OFS_SERIAL_WIDTH: read_word[2:0] = st_reg.serial_width;
      `OFS_AFR_ENABLE: read_word[0] = st_reg.afr_en;
      `OFS_UNDERRUN: read_word = underrun_count;
      `OFS_LINE_MAX: read_word[11:0] = st_reg.line_max;
      `OFS_FRAC_PCLK: read_word[11:0] = st_reg.frac_pclk;
      `OFS_DUAL_PIXEL: read_word[0] = st_reg.dual_pixel;
      `OFS_IRQ_STATUS: read_word[`IRQ_WIDTH-1:0] = st_reg.irq_status;
      `OFS_IRQ_MASK: read_word[`IRQ_WIDTH-1:0] = st_reg.irq_mask;
      default: read_word = 32'h00000000;
    endcase
  end

  // Interrupt events and read-to-clear
  always_comb
  begin
    irq_events = '0;
    irq_events[`IRQ_BIT_UNDERRUN] = underrun_bumped;
    irq_events[`IRQ_BIT_FPC_CMD] = FPC_CMD_VALID;
    irq_read_clr = '0;
    if (addr_take && !HWRITE && HADDR == `OFS_IRQ_STATUS)
    begin
      irq_read_clr = '1;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Writes land in the data phase; a command update in the same cycle
  // as a host write of the fractional clock loses, since the host write is the later intent
  always_comb
  begin
    st_next = st_reg;
    st_next.phase = addr_take ? misc_cfg_pkg::PH_DATA
                              : misc_cfg_pkg::PH_IDLE;
    if (addr_take)
    begin
      st_next.addr = HADDR;
      st_next.wr = HWRITE;
      if (!HWRITE)
      begin
        st_next.rdata = read_word;
      end
    end
    if (FPC_CMD_VALID)
    begin
      st_next.frac_pclk = FPC_CMD_DATA;
    end
    if (wr_now)
    begin
      unique case (st_reg.addr)
        `OFS_SERIAL_WIDTH: st_next.serial_width = HWDATA[2:0];
        `OFS_AFR_ENABLE: st_next.afr_en = HWDATA[0];
        `OFS_LINE_MAX: st_next.line_max = HWDATA[11:0];
        `OFS_FRAC_PCLK: st_next.frac_pclk = HWDATA[11:0];
        `OFS_DUAL_PIXEL: st_next.dual_pixel = HWDATA[0];
        `OFS_IRQ_MASK: st_next.irq_mask = HWDATA[`IRQ_WIDTH-1:0];
        default: st_next.irq_mask = st_reg.irq_mask;
      endcase
    end
    // Set wins over a read-clear in the same cycle
    st_next.irq_status = (st_reg.irq_status & ~irq_read_clr) | irq_events;
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_reg.phase <= misc_cfg_pkg::PH_IDLE;
      st_reg.addr <= 12'h000;
      st_reg.wr <= 1'b0;
      st_reg.rdata <= 32'h00000000;
      st_reg.serial_width <= `RST_SERIAL_WIDTH;
      st_reg.afr_en <= `RST_AFR_ENABLE;
      st_reg.line_max <= `RST_LINE_MAX;
      st_reg.frac_pclk <= `RST_FRAC_PCLK;
      st_reg.dual_pixel <= `RST_DUAL_PIXEL;
      st_reg.irq_status <= '0;
      st_reg.irq_mask <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Zero-wait slave, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = st_reg.rdata;
  assign LANE_WIDTH = st_reg.serial_width[1:0];
  assign READ_DUMMY_EN = st_reg.serial_width[`SW_DUMMY_BIT];
  assign AFR_EN = st_reg.afr_en;
  assign LINE_MAX = st_reg.line_max;
  assign ADAPT_HSYNC_EN = |st_reg.line_max;
  assign FPC_RANGE = st_reg.frac_pclk[11:`FPC_RANGE_LSB];
  assign FPC_FREQ = st_reg.frac_pclk[9:0];
  // Fractional setting only matters when external sync is chosen
  assign FPC_ACTIVE = EXT_SYNC_SEL;
  assign DUAL_PIXEL = st_reg.dual_pixel;
  assign IRQ = |(st_reg.irq_status & st_reg.irq_mask);

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Reads: the word is the one that stood at the address edge, so a
  // write landing on that same edge is not yet visible
  AST_ID_READ: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_CHIP_IDENTITY
    |=> HRDATA == {24'h000000, `CHIP_ID_VALUE})
    else $error("Identity read returned wrong word");
  AST_SW_READ: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_SERIAL_WIDTH
    |=> HRDATA == {29'h0000000, $past(READ_DUMMY_EN), $past(LANE_WIDTH)})
    else $error("Serial width readback mismatch");
  AST_AFR_READ: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_AFR_ENABLE
    |=> HRDATA == {31'h00000000, $past(AFR_EN)})
    else $error("Frame-rate enable readback mismatch");
  AST_UNDERRUN_RD: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_UNDERRUN
    |=> HRDATA == $past(underrun_count))
    else $error("Underrun readback mismatch");
  AST_LMAX_READ: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_LINE_MAX
    |=> HRDATA == {20'h00000, $past(LINE_MAX)})
    else $error("Line maximum readback mismatch");
  AST_FPC_READ: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_FRAC_PCLK
    |=> HRDATA == {20'h00000, $past(FPC_RANGE), $past(FPC_FREQ)})
    else $error("Fractional clock readback mismatch");
  AST_RSVD_ZERO: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_DUAL_PIXEL
    |=> HRDATA[31:1] == 31'h00000000)
    else $error("Reserved bits read nonzero");

  // Writes land at the edge that ends the data phase
  AST_DUMMY_BIT: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    wr_now && st_reg.addr == `OFS_SERIAL_WIDTH
    |=> READ_DUMMY_EN == $past(HWDATA[2]))
    else $error("Dummy byte enable not taken from bit 2");
  AST_LANE_WR: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    wr_now && st_reg.addr == `OFS_SERIAL_WIDTH
    |=> LANE_WIDTH == $past(HWDATA[1:0]))
    else $error("Lane width not updated");
  AST_AFR_WR: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    wr_now && st_reg.addr == `OFS_AFR_ENABLE
    |=> AFR_EN == $past(HWDATA[0]))
    else $error("Frame-rate enable not updated");
  AST_LINE_MAX: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    wr_now && st_reg.addr == `OFS_LINE_MAX
    |=> LINE_MAX == $past(HWDATA[11:0]))
    else $error("Line maximum not updated");
  AST_AH_OFF: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    wr_now && st_reg.addr == `OFS_LINE_MAX
    |=> ADAPT_HSYNC_EN == ($past(HWDATA[11:0]) != 12'h000))
    else $error("Adaptive sync enable disagrees with written maximum");
  AST_FPC_WR: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    wr_now && st_reg.addr == `OFS_FRAC_PCLK
    |=> FPC_RANGE == $past(HWDATA[11:10])
        && FPC_FREQ == $past(HWDATA[9:0]))
    else $error("Fractional clock write not split correctly");
  AST_DUAL_WR: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    wr_now && st_reg.addr == `OFS_DUAL_PIXEL
    |=> DUAL_PIXEL == $past(HWDATA[0]))
    else $error("Dual-pixel bit not updated");

  // Command updates lose to a host write of the fractional clock landing on the same edge
  AST_FPC_CMD: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    FPC_CMD_VALID && !wr_now
    |=> {FPC_RANGE, FPC_FREQ} == $past(FPC_CMD_DATA))
    else $error("Pixel frequency command not applied");

  // Settings must not drift between writes; a stray change here would
  // retime the panel with no software action behind it
  AST_SW_HOLD: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    !(wr_now && st_reg.addr == `OFS_SERIAL_WIDTH)
    |=> $stable({READ_DUMMY_EN, LANE_WIDTH}))
    else $error("Serial width moved without a write");
  AST_AFR_HOLD: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    !(wr_now && st_reg.addr == `OFS_AFR_ENABLE)
    |=> $stable(AFR_EN))
    else $error("Frame-rate enable moved without a write");
  AST_LMAX_HOLD: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    !(wr_now && st_reg.addr == `OFS_LINE_MAX)
    |=> $stable({ADAPT_HSYNC_EN, LINE_MAX}))
    else $error("Line maximum moved without a write");
  AST_FPC_HOLD: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    !FPC_CMD_VALID && !(wr_now && st_reg.addr == `OFS_FRAC_PCLK)
    |=> $stable({FPC_RANGE, FPC_FREQ}))
    else $error("Fractional clock moved with no write or command");
  AST_DUAL_HOLD: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    !(wr_now && st_reg.addr == `OFS_DUAL_PIXEL)
    |=> $stable(DUAL_PIXEL))
    else $error("Dual-pixel bit moved without a write");

  // Sticky status: set two edges after an underrun strobe, one after
  // a command; a read clears it unless an event lands on that edge
  AST_UR_STATUS: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    LINE_UNDERRUN
    |=> ##1 st_reg.irq_status[`IRQ_BIT_UNDERRUN])
    else $error("Underrun did not set its status bit");
  AST_CMD_STATUS: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    FPC_CMD_VALID
    |=> st_reg.irq_status[`IRQ_BIT_FPC_CMD])
    else $error("Command update did not set its status bit");
  AST_STATUS_CLR: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_IRQ_STATUS && irq_events == '0
    |=> st_reg.irq_status == '0)
    else $error("Status read did not clear the sticky bits");

  // Main scenarios
  COV_ID_READ: cover property (@(posedge MCLK) disable iff (!RSTN)
    addr_take && !HWRITE && HADDR == `OFS_CHIP_IDENTITY);
  COV_UNDERRUN_IRQ: cover property (@(posedge MCLK) disable iff (!RSTN)
    LINE_UNDERRUN ##2 IRQ);
  COV_FPC_CMD: cover property (@(posedge MCLK) disable iff (!RSTN)
    FPC_CMD_VALID);
  COV_QUAD: cover property (@(posedge MCLK) disable iff (!RSTN)
    LANE_WIDTH == 2'h2);
endmodule
`default_nettype wire

/* testbench/host_model.sv */
/*
 * Host processor model: an AHB-Lite master doing single word transfers.
 * Assumes the one slave's HREADYOUT comes back as hready.
 */
`default_nettype none
module host_model (
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero, word size only
  initial
  begin
    hsel = 1'b1;
    haddr = 12'hFFF;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'hA5A5A5A5;
  end

  // ****************************************************************
  // One transfer: address phase, then data phase
  // ****************************************************************
  // Released lines flip so a stale value is never mistaken for data
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

/* testbench/tb_display_misc_config_regs.sv */
/*
 * Self-checking bench of the configuration register bank.
 * Assumes the host model drives the bus; HREADY is fed from HREADYOUT.
 */
`include "misc_cfg_consts.svh"
`default_nettype none
module tb_display_misc_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic line_underrun = 1'b0;
  logic fpc_cmd_valid = 1'b0;
  logic [11:0] fpc_cmd_data = 12'h000;
  logic ext_sync_sel = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, read_dummy_en, afr_en, irq;
  logic adapt_hsync_en, fpc_active, dual_pixel;
  logic [11:0] haddr, line_max;
  logic [1:0] htrans, lane_width, fpc_range;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [9:0] fpc_freq;
  int err_total = 0;
  int n_tests = 0;

  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;

  host_model u_host_model (.mclk(mclk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  misc_cfg_regs u_misc_cfg_regs (.MCLK(mclk), .RSTN(rstn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .LINE_UNDERRUN(line_underrun),
    .FPC_CMD_VALID(fpc_cmd_valid), .FPC_CMD_DATA(fpc_cmd_data),
    .EXT_SYNC_SEL(ext_sync_sel), .LANE_WIDTH(lane_width),
    .READ_DUMMY_EN(read_dummy_en), .AFR_EN(afr_en),
    .ADAPT_HSYNC_EN(adapt_hsync_en), .LINE_MAX(line_max),
    .FPC_RANGE(fpc_range), .FPC_FREQ(fpc_freq), .FPC_ACTIVE(fpc_active),
    .DUAL_PIXEL(dual_pixel), .IRQ(irq));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Outputs are looked at on the falling edge, once the write has landed
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host_model.xfer(1'b1, a, d, q);
    @(negedge mclk);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a,
    input logic [31:0] exp);
    logic [31:0] q;
    u_host_model.xfer(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask

  // Back-to-back underrun strobes, n edges long
  task automatic pulse_ur(input int n);
    @(posedge mclk);
    line_underrun <= 1'b1;
    repeat (n) @(posedge mclk);
    line_underrun <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [11:0] ofs [7] = '{`OFS_CHIP_IDENTITY, `OFS_SERIAL_WIDTH,
      `OFS_AFR_ENABLE, `OFS_UNDERRUN, `OFS_LINE_MAX, `OFS_FRAC_PCLK,
      `OFS_DUAL_PIXEL};
    logic [31:0] rv [7] = '{{24'h0, `CHIP_ID_VALUE}, 32'h0, 32'h1, 32'h0,
      32'h0, 32'h8A, 32'h0};
    chk("reset outs", {lane_width, read_dummy_en, afr_en, adapt_hsync_en,
      fpc_range, fpc_freq, dual_pixel, irq},
      {2'h0, 3'h2, 2'h0, 10'h08A, 2'h0});
    chk("reset bus", {hreadyout, hresp, line_max}, {2'h2, 12'h000});
    for (int i = 0; i < 7; i++)
      rd_chk("reset read", ofs[i], rv[i]);
  endtask

  // All-ones writes: reserved bits and read-only places must not keep them
  task automatic t_rw;
    logic [11:0] ofs [8] = '{`OFS_CHIP_IDENTITY, `OFS_SERIAL_WIDTH,
      `OFS_AFR_ENABLE, `OFS_UNDERRUN, `OFS_LINE_MAX, `OFS_FRAC_PCLK,
      `OFS_DUAL_PIXEL, 12'h700};
    logic [31:0] rv [8] = '{{24'h0, `CHIP_ID_VALUE}, 32'h7, 32'h1, 32'h0,
      32'hFFF, 32'hFFF, 32'h1, 32'h0};
    // Line max of all ones exceeds any line cycle count
    for (int i = 0; i < 8; i++)
      wr(ofs[i], 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++)
      rd_chk("masked read", ofs[i], rv[i]);
    chk("set outs", {lane_width, read_dummy_en, afr_en, adapt_hsync_en,
      fpc_range, fpc_freq, dual_pixel, line_max},
      {5'h1F, 12'hFFF, 1'b1, 12'hFFF});
    // No horizontal timing is set here, so odd values never arise
    wr(`OFS_LINE_MAX, 32'h0);
    wr(`OFS_AFR_ENABLE, 32'h0);
    wr(`OFS_DUAL_PIXEL, 32'h0);
    chk("clear outs", {afr_en, adapt_hsync_en, dual_pixel},
      3'h0);
  endtask

  task automatic t_lanes;
    for (int i = 0; i < 8; i++)
    begin
      wr(`OFS_SERIAL_WIDTH, 32'(i));
      chk("lane code", {read_dummy_en, lane_width}, 32'(i));
    end
  endtask

  // Host samples the counter as it would at each frame swap
  task automatic t_underrun;
    wr(`OFS_IRQ_MASK, 32'h1);
    pulse_ur(3);
    chk("irq set", irq, 1'b1);
    rd_chk("count", `OFS_UNDERRUN, 32'h3);
    rd_chk("status", `OFS_IRQ_STATUS, 32'h1);
    rd_chk("status clr", `OFS_IRQ_STATUS, 32'h0);
    chk("irq clr", irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h0);
    pulse_ur(1);
    chk("irq masked", irq, 1'b0);
    rd_chk("count", `OFS_UNDERRUN, 32'h4);
    rd_chk("status", `OFS_IRQ_STATUS, 32'h1);
  endtask

  task automatic t_cmd;
    @(posedge mclk);
    ext_sync_sel <= 1'b1;
    fpc_cmd_valid <= 1'b1;
    fpc_cmd_data <= 12'h5C3;
    @(posedge mclk);
    fpc_cmd_valid <= 1'b0;
    fpc_cmd_data <= 12'hA3C;
    @(negedge mclk);
    chk("cmd outs", {fpc_active, fpc_range, fpc_freq},
      13'h15C3);
    wr(`OFS_IRQ_MASK, 32'h2);
    chk("irq cmd", irq, 1'b1);
    rd_chk("frac reg", `OFS_FRAC_PCLK, 32'h5C3);
    rd_chk("status", `OFS_IRQ_STATUS, 32'h2);
    ext_sync_sel <= 1'b0;
    @(negedge mclk);
    chk("ext off", {irq, fpc_active}, 2'h0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_rw();
    t_lanes();
    t_underrun();
    t_cmd();
    // Second reset in mid-run must restore every default
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    t_reset();
    final_report();
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
